// [inc/xar_consts.vh]
// Constants for the extended attribute resolver: field positions, codes,
// register offsets, reset values and scan geometry.
// Assumes it is included by bare name from each design file that needs it.
//
// What this block does
// - An extended field attribute splits into highlight bits 7:6, colour bits 5:3, symbol set 2:0.
// - Highlight 00 is normal, 01 blinking, 10 reverse video and 11 underlined.
// - Colour 000 is the base colour, and 001 to 111 are blue, red, magenta, green, cyan, yellow, white.
// - Symbol set 000 is base, 001 the alternate language set, 010 to 111 loadable sets two to seven.
// - A character whose extended character attribute is zero takes the held extended field attribute.
// - A nonzero extended character attribute affects only its own character, never later ones.
// - Each zero field of an extended character attribute is taken from the held extended field attribute.
// - The most recent attribute byte is held and governs every following character until replaced or until a new scan starts at position zero.
// - The screen is one run of 1920 positions, and line ends never touch the held attributes.
// - Every position holding an attribute byte is shown as a blank character.
// - The attribute byte ahead of a field sets protection, numeric and intensity of its characters.
`ifndef XAR_CONSTS_VH
`define XAR_CONSTS_VH

// ****************************************
// Buffer byte layout
// ****************************************
`define XAR_ATTR_ID_HI 7
`define XAR_ATTR_ID_LO 6
`define XAR_ATTR_ID 2'h3
`define XAR_FA_PROT_BIT 5
`define XAR_FA_NUM_BIT 4
`define XAR_FA_INT_HI 3
`define XAR_FA_INT_LO 2
`define XAR_FA_MDT_BIT 0
`define XAR_BLANK_CHAR 8'h10

// ****************************************
// Extended attribute layout and codes
// ****************************************
`define XAR_HL_HI 7
`define XAR_HL_LO 6
`define XAR_COL_HI 5
`define XAR_COL_LO 3
`define XAR_SYM_HI 2
`define XAR_SYM_LO 0
`define XAR_HL_NORMAL 2'h0
`define XAR_HL_BLINK 2'h1
`define XAR_HL_REVERSE 2'h2
`define XAR_HL_UNDERLINE 2'h3
`define XAR_COL_BASE 3'h0
`define XAR_COL_WHITE 3'h7
`define XAR_SYM_BASE 3'h0
`define XAR_SYM_ALT_LANG 3'h1
`define XAR_SYM_LOADABLE_SIZE 191

// ****************************************
// Reset values of held attributes
// ****************************************
`define XAR_FA_RESET 8'hc0
`define XAR_EFA_RESET 8'h00

// ****************************************
// Scan geometry
// ****************************************
`define XAR_SCREEN_POSITIONS 11'd1920
`define XAR_LAST_POSITION 11'd1919

// ****************************************
// Output word layout (buffer entry)
// ****************************************
`define XAR_WORD_W 32

// ****************************************
// Wishbone register map
// ****************************************
`define XAR_REG_CTRL 2'h0
`define XAR_REG_STATUS 2'h1
`define XAR_REG_COUNT 2'h2
`define XAR_CTRL_EN_BIT 0
`define XAR_CTRL_RESTART_BIT 1
`define XAR_CTRL_RESET 2'h1

`endif

// [src/xar_merge.v]
// Merges a held extended field attribute with one extended character attribute.
// Assumes both bytes are stable inputs from logic on the same clock.
`timescale 1ns/1ps
`include "xar_consts.vh"

module xar_merge (
	// Attribute bytes
	input wire [7:0] efa_i,
	input wire [7:0] eca_i,
	// Resolved fields
	output wire [1:0] hl_o,
	output wire [2:0] col_o,
	output wire [2:0] sym_o
);

	// ****************************************
	// Field pick
	// ****************************************

	// A zero field of the character byte falls back to the field byte
	function [2:0] xar_pick;
		input [2:0] char_f;
		input [2:0] field_f;
		begin
			xar_pick = (char_f != 3'h0) ? char_f : field_f;
		end
	endfunction

	// Same layout for both bytes, so the all-zero byte reduces to the field byte
	wire [2:0] hl_pick;
	assign hl_pick = xar_pick({1'b0, eca_i[`XAR_HL_HI:`XAR_HL_LO]},
		{1'b0, efa_i[`XAR_HL_HI:`XAR_HL_LO]});
	assign hl_o = hl_pick[1:0];
	assign col_o = xar_pick(eca_i[`XAR_COL_HI:`XAR_COL_LO],
		efa_i[`XAR_COL_HI:`XAR_COL_LO]);
	assign sym_o = xar_pick(eca_i[`XAR_SYM_HI:`XAR_SYM_LO],
		efa_i[`XAR_SYM_HI:`XAR_SYM_LO]);

endmodule

// [src/xar_fifo2.v]
// Two-entry buffer with valid and ready on both sides.
// Assumes producer and consumer share clk_i; storage is flip-flops by index.
`timescale 1ns/1ps
`include "xar_consts.vh"

module xar_fifo2 (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Fill side
	input wire wr_valid_i,
	output wire wr_ready_o,
	input wire [`XAR_WORD_W-1:0] wr_data_i,
	// Drain side
	output wire rd_valid_o,
	input wire rd_ready_i,
	output wire [`XAR_WORD_W-1:0] rd_data_o
);

	reg [`XAR_WORD_W-1:0] mem_r [0:1];
	reg wr_idx_r;
	reg rd_idx_r;
	reg [1:0] count_r;
	wire push;
	wire pop;

	// Full only at two entries, so a stalled reader really fills it
	assign wr_ready_o = (count_r != 2'h2);
	assign rd_valid_o = (count_r != 2'h0);
	assign rd_data_o = mem_r[rd_idx_r];
	assign push = wr_valid_i & wr_ready_o;
	assign pop = rd_valid_o & rd_ready_i;

	// Storage write, no reset needed on data
	always @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_idx_r] <= wr_data_i;
		end
	end

	// Pointers and occupancy
	always @(posedge clk_i) begin
		if (rst_i) begin
			wr_idx_r <= 1'b0;
			rd_idx_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) begin
				wr_idx_r <= ~wr_idx_r;
			end
			if (pop) begin
				rd_idx_r <= ~rd_idx_r;
			end
			if (push & ~pop) begin
				count_r <= count_r + 2'h1;
			end else if (pop & ~push) begin
				count_r <= count_r - 2'h1;
			end
		end
	end

endmodule

// [src/xar_resolver.v]
// Extended attribute resolver: scans buffer bytes with their extended
// attribute bytes and emits per-position display attributes.
// Assumes the buffer reader sits on clk_i and the renderer drains the output
// stream; software reaches control and status over classic Wishbone.
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "xar_consts.vh"

module xar_resolver (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// Buffer reader stream
	input wire in_valid_i,
	output wire in_ready_o,
	input wire in_sof_i,
	input wire [7:0] in_byte_i,
	input wire [7:0] in_ext_i,
	// Renderer stream
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [7:0] out_char_o,
	output wire out_is_attr_o,
	output wire [1:0] out_highlight_o,
	output wire [2:0] out_color_o,
	output wire [2:0] out_symbol_set_o,
	output wire out_protected_o,
	output wire out_numeric_o,
	output wire [1:0] out_intensity_o,
	output wire [10:0] out_position_o
);

	// ****************************************
	// Declarations
	// ****************************************

	// Scan states, one-hot
	localparam ST_IDLE = 2'b01;
	localparam ST_SCAN = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [7:0] field_attr_r;
	reg [7:0] field_attr_nxt;
	reg [7:0] extended_field_attr_r;
	reg [7:0] extended_field_attr_nxt;
	reg [10:0] pos_r;
	reg [10:0] pos_nxt;
	reg [15:0] attr_count_r;
	reg [15:0] attr_count_nxt;
	reg ctrl_en_r;
	reg restart_r;
	reg wb_ack_r;
	reg [31:0] wb_dat_r;

	wire accept;
	wire scan_start;
	wire is_attr;
	wire [7:0] cur_fa;
	wire [7:0] cur_efa;
	wire [7:0] extended_char_attr;
	wire [1:0] res_hl;
	wire [2:0] res_col;
	wire [2:0] res_sym;
	wire fifo_wr_ready;
	wire [`XAR_WORD_W-1:0] fifo_wr_data;
	wire [`XAR_WORD_W-1:0] fifo_rd_data;
	wire wb_req;
	wire [1:0] wb_index;

	// ****************************************
	// Helper functions
	// ****************************************

	// A buffer byte is an attribute when its identifier bits are both set
	function xar_is_attr;
		input [7:0] b;
		begin
			xar_is_attr = (b[`XAR_ATTR_ID_HI:`XAR_ATTR_ID_LO] == `XAR_ATTR_ID);
		end
	endfunction

	// Next linear position; the screen is one run, wrap only at its end
	function [10:0] xar_next_pos;
		input [10:0] p;
		begin
			if (p == `XAR_LAST_POSITION) begin
				xar_next_pos = 11'd0;
			end else begin
				xar_next_pos = p + 11'd1;
			end
		end
	endfunction

	// ****************************************
	// Input side
	// ****************************************

	// Stall the reader while disabled, restarting or while the output buffer is full;
	// a byte taken in the restart cycle would lose its effect on the held attributes
	assign in_ready_o = ctrl_en_r & fifo_wr_ready & (state_r == ST_SCAN) & ~restart_r;
	assign accept = in_valid_i & in_ready_o;

	// A new scan begins on the reader's marker or at position zero
	assign scan_start = in_sof_i | (pos_r == 11'd0);

	// Held values, with the scan-start clear applied before this byte
	assign cur_fa = scan_start ? `XAR_FA_RESET : field_attr_r;
	assign cur_efa = scan_start ? `XAR_EFA_RESET : extended_field_attr_r;

	assign is_attr = xar_is_attr(in_byte_i);

	// The attribute position carries its own field byte; characters use their own byte
	assign extended_char_attr = is_attr ? 8'h00 : in_ext_i;

	// ****************************************
	// Resolution
	// ****************************************

	// An attribute position resolves against its freshly taken field byte
	xar_merge u_merge (
		.efa_i(is_attr ? in_ext_i : cur_efa),
		.eca_i(extended_char_attr),
		.hl_o(res_hl),
		.col_o(res_col),
		.sym_o(res_sym)
	);

	// Pack one output word; attribute positions render as blanks
	assign fifo_wr_data = {
		out_word_pos(scan_start),
		(is_attr ? `XAR_BLANK_CHAR : in_byte_i),
		is_attr,
		res_hl,
		res_col,
		res_sym,
		(is_attr ? in_byte_i[`XAR_FA_PROT_BIT] : cur_fa[`XAR_FA_PROT_BIT]),
		(is_attr ? in_byte_i[`XAR_FA_NUM_BIT] : cur_fa[`XAR_FA_NUM_BIT]),
		(is_attr ? in_byte_i[`XAR_FA_INT_HI:`XAR_FA_INT_LO]
			: cur_fa[`XAR_FA_INT_HI:`XAR_FA_INT_LO])
	};

	// Position of the byte being taken
	function [10:0] out_word_pos;
		input st;
		begin
			out_word_pos = st ? 11'd0 : pos_r;
		end
	endfunction

	// ****************************************
	// Output buffer
	// ****************************************

	// Two entries so a renderer stall never drops a resolved word
	xar_fifo2 u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_valid_i(accept),
		.wr_ready_o(fifo_wr_ready),
		.wr_data_i(fifo_wr_data),
		.rd_valid_o(out_valid_o),
		.rd_ready_i(out_ready_i),
		.rd_data_o(fifo_rd_data)
	);

	// Word fields out of buffer flops
	assign out_position_o = fifo_rd_data[31:21];
	assign out_char_o = fifo_rd_data[20:13];
	assign out_is_attr_o = fifo_rd_data[12];
	assign out_highlight_o = fifo_rd_data[11:10];
	assign out_color_o = fifo_rd_data[9:7];
	assign out_symbol_set_o = fifo_rd_data[6:4];
	assign out_protected_o = fifo_rd_data[3];
	assign out_numeric_o = fifo_rd_data[2];
	assign out_intensity_o = fifo_rd_data[1:0];

	// ****************************************
	// Held attributes and scan position
	// ****************************************

	// Next-state logic for the scan
	always @* begin
		state_nxt = state_r;
		field_attr_nxt = field_attr_r;
		extended_field_attr_nxt = extended_field_attr_r;
		pos_nxt = pos_r;
		attr_count_nxt = attr_count_r;
		case (state_r)
			ST_IDLE: begin
				// One settling cycle after reset or restart before bytes are taken
				state_nxt = ST_SCAN;
			end
			ST_SCAN: begin
				if (accept) begin
					field_attr_nxt = cur_fa;
					extended_field_attr_nxt = cur_efa;
					if (is_attr) begin
						// A new attribute replaces the held pair for what follows
						field_attr_nxt = in_byte_i;
						extended_field_attr_nxt = in_ext_i;
						attr_count_nxt = attr_count_r + 16'h0001;
					end
					// Line ends are not special; only the last position wraps
					pos_nxt = xar_next_pos(scan_start ? 11'd0 : pos_r);
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Scan registers; restart forces a fresh scan from position zero
	always @(posedge clk_i) begin
		if (rst_i | restart_r) begin
			state_r <= ST_IDLE;
			field_attr_r <= `XAR_FA_RESET;
			extended_field_attr_r <= `XAR_EFA_RESET;
			pos_r <= 11'd0;
		end else begin
			state_r <= state_nxt;
			field_attr_r <= field_attr_nxt;
			extended_field_attr_r <= extended_field_attr_nxt;
			pos_r <= pos_nxt;
		end
	end

	// Attribute counter survives restart so software can watch totals
	always @(posedge clk_i) begin
		if (rst_i) begin
			attr_count_r <= 16'h0000;
		end else begin
			attr_count_r <= attr_count_nxt;
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
	assign wb_index = wb_adr_i[3:2];
	assign wb_ack_o = wb_ack_r;
	assign wb_dat_o = wb_dat_r;

	// One wait state answer; ack drops the cycle after it was given
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h00000000;
			ctrl_en_r <= `XAR_CTRL_RESET >> 0 != 2'h0;
			restart_r <= 1'b0;
		end else begin
			wb_ack_r <= wb_req;
			restart_r <= 1'b0;
			if (wb_req & wb_we_i & wb_sel_i[0] & (wb_index == `XAR_REG_CTRL)) begin
				ctrl_en_r <= wb_dat_i[`XAR_CTRL_EN_BIT];
				restart_r <= wb_dat_i[`XAR_CTRL_RESTART_BIT];
			end
			if (wb_req) begin
				case (wb_index)
					`XAR_REG_CTRL: wb_dat_r <= {31'h00000000, ctrl_en_r};
					`XAR_REG_STATUS: wb_dat_r <= {field_attr_r, extended_field_attr_r,
						state_r == ST_SCAN, 4'h0, pos_r};
					`XAR_REG_COUNT: wb_dat_r <= {16'h0000, attr_count_r};
					default: wb_dat_r <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [verif/xar_render_model.sv]
// Renderer model: takes resolved positions, stalls when the bench asks.
// Assumes the bench drives stall_i from clk_i.
`timescale 1ns/1ps

module xar_render_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Stall request
	input wire logic stall_i,
	// Renderer stream
	output logic out_ready_o
);
	// Ready lags the stall by a cycle, as a pipelined sink would
	always @(posedge clk_i) begin
		if (rst_i)
			out_ready_o <= 1'b0;
		else
			out_ready_o <= !stall_i;
	end
endmodule

// [verif/xar_resolver_asserts.sv]
// Checker for the resolver ports; keeps its own copy of the held attributes.
// Assumes it is bound to xar_resolver; a restart write is followed like a reset.
`timescale 1ns/1ps

module xar_chk (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// Streams
	input wire in_valid_i,
	input wire in_ready_o,
	input wire in_sof_i,
	input wire [7:0] in_byte_i,
	input wire [7:0] in_ext_i,
	input wire out_valid_o,
	input wire out_ready_i,
	input wire [7:0] out_char_o,
	input wire out_is_attr_o,
	input wire [1:0] out_highlight_o,
	input wire [2:0] out_color_o,
	input wire [2:0] out_symbol_set_o,
	input wire out_protected_o,
	input wire out_numeric_o,
	input wire [1:0] out_intensity_o,
	input wire [10:0] out_position_o
);
	// ****
	// Held attribute shadow
	// ****
	reg [10:0] pos_r;
	reg [7:0] efa_r;
	reg [7:0] fa_r;
	reg rs_r;
	wire [10:0] sp = in_sof_i ? 11'h0 : pos_r;
	wire st = sp == 11'h0;
	wire at = in_byte_i[7:6] == 2'h3;
	wire [7:0] x = in_ext_i;
	wire [7:0] efa_nxt = at ? x : (st ? 8'h00 : efa_r);
	wire [7:0] fa_nxt = at ? in_byte_i : (st ? 8'hc0 : fa_r);
	// Zero fields of the character byte fall back to the field byte
	wire [1:0] hl = |x[7:6] ? x[7:6] : efa_nxt[7:6];
	wire [2:0] co = |x[5:3] ? x[5:3] : efa_nxt[5:3];
	wire [2:0] sy = |x[2:0] ? x[2:0] : efa_nxt[2:0];
	wire [7:0] ch = at ? 8'h10 : in_byte_i;
	// Restart write seen on the bus, applied one edge later as the design does
	always @(posedge clk_i) begin
		if (rst_i)
			rs_r <= 1'b0;
		else
			rs_r <= wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
				&& wb_adr_i[3:2] == 2'h0 && wb_dat_i[1];
	end
	// Shadow follows each taken pair
	always @(posedge clk_i) begin
		if (rst_i || rs_r) begin
			pos_r <= 11'h0;
			efa_r <= 8'h00;
			fa_r <= 8'hc0;
		end else if (in_valid_i && in_ready_o) begin
			pos_r <= (sp == 11'h77f) ? 11'h0 : sp + 11'h1;
			efa_r <= efa_nxt;
			fa_r <= fa_nxt;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Only an empty buffer lets the next word be tied to one take
	sequence take_empty_s;
		in_valid_i && in_ready_o && !out_valid_o;
	endsequence
	sequence wb_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	hl_merge_a: assert property (take_empty_s |=> out_highlight_o == $past(hl))
		else $error("highlight wrong");
	col_merge_a: assert property (take_empty_s |=> out_color_o == $past(co))
		else $error("colour wrong");
	sym_merge_a: assert property (take_empty_s |=> out_symbol_set_o == $past(sy))
		else $error("symbol set wrong");
	field_attr_a: assert property (take_empty_s |=> {out_protected_o, out_numeric_o,
		out_intensity_o} == $past(fa_nxt[5:2])) else $error("field attribute wrong");
	blank_char_a: assert property (take_empty_s |=> out_char_o == $past(ch)
		&& out_is_attr_o == $past(at)) else $error("blank wrong");
	scan_pos_a: assert property (take_empty_s |=> out_position_o == $past(sp))
		else $error("position wrong");
	take_out_a: assert property (in_valid_i && in_ready_o |=> out_valid_o)
		else $error("no output after take");
	out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o
		&& $stable({out_char_o, out_position_o, out_highlight_o})) else $error("output moved");
	wb_answer_a: assert property (wb_req_s |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	unmapped_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h3
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	restart_refuse_a: assert property (rs_r |-> !in_ready_o)
		else $error("byte taken during restart");
endmodule

bind xar_resolver xar_chk xar_chk_inst (.*);

// [verif/xar_resolver_bench.sv]
// Bench for the resolver: drives the reader side, notes expected words.
// Assumes the renderer model and the bound checker beside the design.
`timescale 1ns/1ps
`include "xar_consts.vh"

module xar_resolver_bench;
	// ****
	// Signals and bench state
	// ****
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic in_valid_i = 1'b0;
	logic in_sof_i = 1'b0;
	logic [7:0] in_byte_i = 8'h0;
	logic [7:0] in_ext_i = 8'h0;
	logic stall = 1'b1;
	logic rmode = 1'b0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, in_ready_o, out_valid_o, out_ready_i, out_is_attr_o;
	wire out_protected_o, out_numeric_o;
	wire [7:0] out_char_o;
	wire [1:0] out_highlight_o, out_intensity_o;
	wire [2:0] out_color_o, out_symbol_set_o;
	wire [10:0] out_position_o;
	int err_count = 0;
	int checks = 0;
	int i;
	logic [31:0] seed = 32'ha5711bfe;
	logic [31:0] rd;
	logic [31:0] expq[$];
	logic [10:0] pos = 11'h0;
	logic [7:0] efa = 8'h00;
	logic [7:0] fa = 8'hc0;
	xar_resolver xar_resolver_inst (.*);
	xar_render_model xar_render_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.out_ready_o(out_ready_i));
	// 20 MHz clock
	always #25 clk_i = ~clk_i;
	function void rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One classic cycle; called just after an edge, returns just after one
	task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			err_count++;
			conclude();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Notes the expected word, then offers the pair until it is taken
	task put(input logic sof, input logic [7:0] b, input logic [7:0] x);
		int n;
		logic [10:0] sp;
		sp = sof ? 11'h0 : pos;
		if (sp == 11'h0) begin
			efa = 8'h00;
			fa = 8'hc0;
		end
		if (b[7:6] == 2'h3) begin
			efa = x;
			fa = b;
		end
		expq.push_back({(b[7:6] == 2'h3), sp, (b[7:6] == 2'h3) ? 8'h10 : b,
			|x[7:6] ? x[7:6] : efa[7:6], |x[5:3] ? x[5:3] : efa[5:3],
			|x[2:0] ? x[2:0] : efa[2:0], fa[5:2]});
		pos = (sp == `XAR_LAST_POSITION) ? 11'h0 : sp + 11'h1;
		rnd();
		if (rmode)
			stall <= seed[0];
		in_valid_i <= 1'b1;
		in_sof_i <= sof;
		in_byte_i <= b;
		in_ext_i <= x;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			// A random stall is lifted once it blocks the reader, so no wait hangs
			if (rmode && in_ready_o !== 1'b1)
				stall <= 1'b0;
		end while (in_ready_o !== 1'b1 && n < 40);
		if (in_ready_o !== 1'b1) begin
			err_count++;
			conclude();
		end
	endtask
	// Each accepted output word is matched against the oldest note
	always @(posedge clk_i) begin
		if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
			if (expq.size() == 0)
				cmp(32'h1, 32'h0);
			else
				cmp({out_is_attr_o, out_position_o, out_char_o, out_highlight_o, out_color_o,
					out_symbol_set_o, out_protected_o, out_numeric_o, out_intensity_o},
					expq.pop_front());
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, 4'h0, 32'h0);
		cmp(rd, 32'h1);
		wb(1'b1, 4'hc, 32'hffffffff);
		wb(1'b0, 4'hc, 32'h0);
		cmp(rd, 32'h0);
		wb(1'b1, 4'h0, 32'h0);
		repeat (3) @(posedge clk_i);
		cmp({31'h0, in_ready_o}, 32'h0);
		wb(1'b1, 4'h0, 32'h1);
		stall <= 1'b0;
		repeat (3) @(posedge clk_i);
		// Green unprotected field, one blue override, then a red protected field
		put(1'b1, 8'hc0, 8'h20);
		put(1'b0, 8'ha0, 8'h00);
		put(1'b0, 8'ha1, 8'h00);
		put(1'b0, 8'ha2, 8'h08);
		put(1'b0, 8'ha3, 8'h00);
		put(1'b0, 8'ha4, 8'h81);
		put(1'b0, 8'he0, 8'h10);
		put(1'b0, 8'ha5, 8'h00);
		// Fill the buffer against a stalled renderer until it refuses
		in_valid_i <= 1'b0;
		stall <= 1'b1;
		repeat (2) @(posedge clk_i);
		put(1'b0, 8'h41, 8'h00);
		put(1'b0, 8'h42, 8'h00);
		in_valid_i <= 1'b0;
		@(posedge clk_i);
		cmp({31'h0, out_valid_o}, 32'h1);
		cmp({31'h0, in_ready_o}, 32'h0);
		// Restart clears position and held attributes; the attribute count survives
		wb(1'b1, 4'h0, 32'h3);
		pos = 11'h0;
		wb(1'b0, 4'h4, 32'h0);
		cmp(rd, 32'hc0008000);
		wb(1'b0, 4'h8, 32'h0);
		cmp(rd, 32'h2);
		stall <= 1'b0;
		rmode <= 1'b1;
		// Random run of 2100 pairs, with a fresh scan at pair 1000, so no position passes 1099 and the wrap is never reached
		for (i = 0; i < 2100; i++) begin
			rnd();
			put(i == 1000, (seed[2:0] == 3'h0) ? {2'h3, seed[13:10], 1'b0, seed[9]}
				: {1'b0, seed[14:8]}, seed[3] ? seed[23:16] : 8'h00);
		end
		in_valid_i <= 1'b0;
		rmode <= 1'b0;
		stall <= 1'b0;
		for (i = 0; i < 50 && expq.size() > 0; i++)
			@(posedge clk_i);
		cmp(expq.size(), 32'h0);
		conclude();
	end
endmodule
